// *** inc/hrf_pkg.sv ***
// package: codes and positions for the hart fault-report encoder
// assumes: used by the encoder top and its detail-byte builder
package hrf_pkg;
    // group fault byte bit positions
    localparam int GF_MORE_STATUS_BIT = 0;
    localparam int GF_COMM_ERR_BIT = 1;
    localparam int GF_PARAM_CHECK_BIT = 2;
    localparam int GF_RESERVED_BIT = 3;
    localparam int GF_CLASS_LSB = 4;
    localparam int HART_CMD_MORE_STATUS = 48;

    typedef enum logic [3:0] {
        CLS_UNSPEC = 4'h0,
        CLS_MODEM = 4'h1,
        CLS_CHANNEL = 4'h2,
        CLS_COMMAND = 4'h3,
        CLS_QUERY = 4'h4,
        CLS_RESPONSE = 4'h5,
        CLS_QUERY_REJ = 4'h6,
        CLS_PROFILE_REJ = 4'h7,
        CLS_VENDOR_REJ = 4'h8
    } hrf_class_t;
    localparam logic [3:0] CLS_LAST_USED = 4'h8;

    // modem unit detail codes
    localparam logic [7:0] MDM_INTERNAL_COMM = 8'h01;
    localparam logic [7:0] MDM_PARAM_ASSIGN = 8'h02;
    localparam logic [7:0] MDM_HW_FAULT = 8'h03;
    localparam logic [7:0] MDM_WAIT_EXPIRED = 8'h04;
    localparam logic [7:0] MDM_TIMER_EXPIRED = 8'h05;
    // channel fault detail codes
    localparam logic [7:0] CHF_LINE = 8'h01;
    localparam logic [7:0] CHF_SHORT = 8'h02;
    localparam logic [7:0] CHF_OPEN = 8'h03;
    localparam logic [7:0] CHF_LOW_CURRENT = 8'h04;
    localparam logic [7:0] CHF_PARAM_ASSIGN = 8'h05;
    // query rejected detail codes
    localparam logic [7:0] QRJ_COMPACT = 8'h01;
    localparam logic [7:0] QRJ_CHAINED = 8'h02;
    localparam logic [7:0] QRJ_BAD_CMD = 8'h03;
    localparam logic [7:0] QRJ_NO_RES = 8'h04;
    localparam logic [7:0] QRJ_STANDBY = 8'h05;
    localparam logic [7:0] VENDOR_CODE_MIN = 8'h80;
    localparam logic [7:0] DETAIL_NONE = 8'h00;

    // flag positions in the query and response error detail byte
    localparam int FLG_GAP = 0;
    localparam int FLG_RX_OVF = 1;
    localparam int FLG_TIMEOUT = 2;
    localparam int FLG_CHECKSUM = 3;
    localparam int FLG_FRAMING = 4;
    localparam int FLG_OVERRUN = 5;
    localparam int FLG_PARITY = 6;
    localparam logic [7:0] QUERY_FLAG_MASK = 8'h7A;
    localparam logic [7:0] RESP_FLAG_MASK = 8'h7F;

    // response control result codes and record byte positions
    localparam logic [2:0] RES_ERR_DATA = 3'h6;
    localparam logic [2:0] RES_ERR_NODATA = 3'h7;
    localparam int REC_CTRL_BYTE = 0;
    localparam int REC_GROUP_BYTE = 1;
    localparam int REC_DETAIL_BYTE = 2;
    localparam int REC_DATA_BYTE = 3;

    localparam logic [7:0] GROUP_RESET = 8'h00;
    localparam logic [2:0] RESULT_RESET = 3'h0;
endpackage

// *** inc/hrf_detail_if.sv ***
// interface: carries the fault cause from the top to the detail builder
// assumes: both ends on the same clock
`timescale 1ns/1ps
interface hrf_detail_if;
    logic [3:0] err_class;
    logic [7:0] code;
    logic [6:0] cmd_code;
    logic [7:0] flags;
    logic [7:0] detail;
    logic class_ok;
    modport src (output err_class, code, cmd_code, flags,
                 input detail, class_ok);
    modport enc (input err_class, code, cmd_code, flags,
                 output detail, class_ok);
endinterface

// *** logic/hrf_detail_enc.sv ***
// module: builds the protocol error detail byte from class and cause
// assumes: purely combinational; inputs held stable by the top
`timescale 1ns/1ps
module hrf_detail_enc
    import hrf_pkg::*;
(
    hrf_detail_if.enc dif // fault cause in, detail byte out
);
    // =========================================================
    // code range check
    // =========================================================
    function automatic logic code_legal(input logic [7:0] c,
                                        input logic [7:0] hi);
        code_legal = (c <= hi) || (c >= VENDOR_CODE_MIN);
    endfunction

    wire logic [7:0] modem_detail;
    wire logic [7:0] channel_detail;
    wire logic [7:0] rej_detail;
    wire logic [7:0] cmd_detail;
    wire logic [7:0] query_detail;
    wire logic [7:0] resp_detail;

    // out-of-range reserved codes collapse to "not specified"
    assign modem_detail = code_legal(dif.code, MDM_TIMER_EXPIRED)
        ? dif.code : DETAIL_NONE;
    assign channel_detail = code_legal(dif.code, CHF_PARAM_ASSIGN)
        ? dif.code : DETAIL_NONE;
    assign rej_detail = code_legal(dif.code, QRJ_STANDBY)
        ? dif.code : DETAIL_NONE;
    assign cmd_detail = {1'b0, dif.cmd_code};
    assign query_detail = dif.flags & QUERY_FLAG_MASK;
    assign resp_detail = dif.flags & RESP_FLAG_MASK;

    assign dif.class_ok = (dif.err_class <= CLS_LAST_USED);
    assign dif.detail =
        (dif.err_class == CLS_MODEM) ? modem_detail :
        (dif.err_class == CLS_CHANNEL) ? channel_detail :
        (dif.err_class == CLS_COMMAND) ? cmd_detail :
        (dif.err_class == CLS_QUERY) ? query_detail :
        (dif.err_class == CLS_RESPONSE) ? resp_detail :
        (dif.err_class == CLS_QUERY_REJ) ? rej_detail :
        DETAIL_NONE;
endmodule

// *** logic/hrf_encoder.sv ***
// module: hart response fault encoder, group fault and detail bytes
// assumes: cause inputs come from logic on CLK; LOAD pulses one cycle
// Overview of operation
// - set group bit 0 when field device says more status exists.
// - set group bit 1 when field device reports communication error.
// - group bit 2 is 1 when modem unit parameters need checking.
// - group bits 7..4 carry the error class, codes 0 to 8.
// - modem unit class detail codes 1 to 5, vendor codes from 128.
// - channel fault class detail codes 0 to 5, same ranges.
// - query error detail is flags at bits 1,3,4,5,6.
// - response error detail is flags at bits 0 to 6.
// - query rejected detail codes 1 to 5, vendor codes from 128.
// - reject external requests with standby when channel not active.
// - profile and vendor rejected classes report detail 0 only.
// - error record has group byte at 1, detail at 2.
// - result code 6 for error with data, 7 without data.
`timescale 1ns/1ps
module hrf_encoder
    import hrf_pkg::*;
(
    input wire logic CLK, // 40 MHz clock
    input wire logic SYS_RST, // synchronous reset, active high
    input wire logic LOAD, // one-cycle pulse: latch a new report
    input wire logic MORE_STATUS, // field device has more status
    input wire logic COMM_ERROR, // field device saw a comm error
    input wire logic PARAM_CHANGED, // modem unit parameters changed
    input wire logic [3:0] ERR_CLASS, // protocol error class
    input wire logic [7:0] ERR_CODE, // coded cause for coded classes
    input wire logic [6:0] CMD_CODE, // command error code from device
    input wire logic [7:0] ERR_FLAGS, // raw query/response error flags
    input wire logic HAS_DATA, // response data follows the record
    input wire logic EXT_REQUEST, // request arrives from outside
    input wire logic CHAN_ACTIVE, // channel is active of redundant pair
    output logic [7:0] GROUP_BYTE, // record byte 1
    output logic [7:0] DETAIL_BYTE, // record byte 2
    output logic [2:0] RESULT, // response result field
    output logic ERROR_REC, // record uses the error layout
    output logic DATA_FOLLOWS, // data bytes follow from byte 3
    output logic REPORT_VALID // one-cycle pulse, new report latched
);
    // =========================================================
    // cause selection
    // =========================================================
    hrf_detail_if dif();

    wire logic standby_reject;
    wire logic [3:0] eff_class;
    wire logic [7:0] eff_code;

    // passive channel overrides any other cause for outside requests
    assign standby_reject = EXT_REQUEST && !CHAN_ACTIVE;
    assign eff_class = standby_reject ? CLS_QUERY_REJ : ERR_CLASS;
    assign eff_code = standby_reject ? QRJ_STANDBY : ERR_CODE;

    assign dif.err_class = eff_class;
    assign dif.code = eff_code;
    assign dif.cmd_code = CMD_CODE;
    assign dif.flags = ERR_FLAGS;

    hrf_detail_enc u_detail (
        .dif(dif)
    );

    // =========================================================
    // group byte and result assembly
    // =========================================================
    wire logic [3:0] group_class;
    wire logic [7:0] group_next;
    wire logic [7:0] detail_next;
    wire logic [2:0] result_next;
    wire logic data_next;

    // unused class codes are reported as unspecified
    assign group_class = dif.class_ok ? eff_class : CLS_UNSPEC;
    assign group_next = {group_class,
                         1'b0,
                         PARAM_CHANGED,
                         COMM_ERROR,
                         MORE_STATUS};
    assign detail_next = dif.class_ok ? dif.detail : DETAIL_NONE;
    // standby rejects carry no field device data
    assign data_next = HAS_DATA && !standby_reject;
    assign result_next = data_next ? RES_ERR_DATA
                                   : RES_ERR_NODATA;

    // =========================================================
    // output registers
    // =========================================================
    logic [7:0] group_reg;
    logic [7:0] detail_reg;
    logic [2:0] result_reg;
    logic error_reg;
    logic data_reg;
    logic valid_reg;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            group_reg <= GROUP_RESET;
            detail_reg <= DETAIL_NONE;
            result_reg <= RESULT_RESET;
            error_reg <= 1'b0;
            data_reg <= 1'b0;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= LOAD;
            if (LOAD) begin
                group_reg <= group_next;
                detail_reg <= detail_next;
                result_reg <= result_next;
                error_reg <= 1'b1;
                data_reg <= data_next;
            end
        end
    end

    assign GROUP_BYTE = group_reg;
    assign DETAIL_BYTE = detail_reg;
    assign RESULT = result_reg;
    assign ERROR_REC = error_reg;
    assign DATA_FOLLOWS = data_reg;
    assign REPORT_VALID = valid_reg;
endmodule

// *** test/hrf_encoder_asserts.sv ***
// checker: timing and coding of the fault report outputs
// assumes: bound to the encoder top, one clock domain
`timescale 1ns/1ps
module hrf_encoder_asserts
    import hrf_pkg::*;
(
    input wire logic CLK, // clock
    input wire logic SYS_RST, // sync reset
    input wire logic LOAD, // report strobe
    input wire logic MORE_STATUS, // cause
    input wire logic COMM_ERROR, // cause
    input wire logic PARAM_CHANGED, // cause
    input wire logic [3:0] ERR_CLASS, // cause
    input wire logic [6:0] CMD_CODE, // cause
    input wire logic EXT_REQUEST, // cause
    input wire logic CHAN_ACTIVE, // cause
    input wire logic [7:0] GROUP_BYTE, // record byte 1
    input wire logic [7:0] DETAIL_BYTE, // record byte 2
    input wire logic [2:0] RESULT, // result field
    input wire logic DATA_FOLLOWS, // data flag
    input wire logic REPORT_VALID // report strobe out
);
    // ====================
    // properties
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    wire stby = EXT_REQUEST && !CHAN_ACTIVE;
    sequence s_take;
        LOAD ##1 REPORT_VALID;
    endsequence
    sequence s_cmd;
        LOAD && ERR_CLASS == 4'h3 && !stby;
    endsequence
    AST_TAKE: assert property (LOAD |-> s_take)
        else $error("report strobe missing after load");
    AST_PULSE: assert property (!LOAD |=> !REPORT_VALID)
        else $error("report strobe without load");
    AST_MORE: assert property (LOAD |=> GROUP_BYTE[0] == $past(MORE_STATUS))
        else $error("more status bit wrong");
    AST_COMM: assert property (LOAD |=> GROUP_BYTE[1] == $past(COMM_ERROR))
        else $error("comm error bit wrong");
    AST_PARAM: assert property (LOAD |=> GROUP_BYTE[2] == $past(PARAM_CHANGED))
        else $error("parameter check bit wrong");
    AST_RSVD: assert property (GROUP_BYTE[3] == 1'b0)
        else $error("group bit 3 set");
    AST_CLASS: assert property (GROUP_BYTE[7:4] <= CLS_LAST_USED)
        else $error("unused class reported");
    AST_STBY: assert property (LOAD && stby |=> GROUP_BYTE[7:4] == 4'h6
        && DETAIL_BYTE == QRJ_STANDBY && RESULT == RES_ERR_NODATA)
        else $error("standby rejection wrong");
    AST_CMD: assert property (s_cmd |=> DETAIL_BYTE == {1'b0, $past(CMD_CODE)})
        else $error("command detail wrong");
    AST_RES: assert property (REPORT_VALID |-> RESULT[2:1] == 2'h3
        && DATA_FOLLOWS == (RESULT == RES_ERR_DATA))
        else $error("result field wrong");
    AST_ZERO: assert property (REPORT_VALID && GROUP_BYTE[7:4] inside
        {4'h0, 4'h7, 4'h8} |-> DETAIL_BYTE == 8'h00)
        else $error("detail not zero");
    AST_HOLD: assert property (!LOAD |=> $stable(DETAIL_BYTE))
        else $error("detail changed without load");
endmodule
bind hrf_encoder hrf_encoder_asserts hrf_encoder_asserts_i (.CLK, .SYS_RST,
    .LOAD, .MORE_STATUS, .COMM_ERROR, .PARAM_CHANGED, .ERR_CLASS, .CMD_CODE,
    .EXT_REQUEST, .CHAN_ACTIVE, .GROUP_BYTE, .DETAIL_BYTE, .RESULT,
    .DATA_FOLLOWS, .REPORT_VALID);

// *** test/hrf_field_dev.sv ***
// model: field device status flags seen by the encoder
// assumes: bench sets the wanted status after the clock edge
`timescale 1ns/1ps
module hrf_field_dev (
    input wire logic [1:0] cond, // wanted status: comm, more
    output logic more_status, // more status available
    output logic comm_error // comm error on received command
);
    assign more_status = cond[0];
    assign comm_error = cond[1];
endmodule

// *** test/test_hrf_encoder.sv ***
// bench: drives fault causes, checks report bytes and strobes
// assumes: encoder, field device model and checker compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    fails++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_hrf_encoder
    import hrf_pkg::*;
;
    logic CLK = 0, SYS_RST = 1, LOAD = 0, PARAM_CHANGED = 0, HAS_DATA = 0;
    logic EXT_REQUEST = 0, CHAN_ACTIVE = 1;
    logic [1:0] cond = 0;
    logic [3:0] ERR_CLASS = 0;
    logic [7:0] ERR_CODE = 0, GROUP_BYTE, DETAIL_BYTE, v;
    logic [2:0] RESULT;
    logic MORE_STATUS, COMM_ERROR, ERROR_REC, DATA_FOLLOWS, REPORT_VALID;
    logic [7:0] vals[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
        8'h06, 8'h7F, 8'h80, 8'hFF};
    logic [3:0] cls[3] = '{4'h1, 4'h2, 4'h6};
    int fails = 0, num_checks = 0;
    hrf_field_dev hrf_field_dev_i (.cond(cond), .more_status(MORE_STATUS),
        .comm_error(COMM_ERROR));
    hrf_encoder hrf_encoder_i (.CLK, .SYS_RST, .LOAD, .MORE_STATUS,
        .COMM_ERROR, .PARAM_CHANGED, .ERR_CLASS, .ERR_CODE,
        .CMD_CODE(ERR_CODE[6:0]), .ERR_FLAGS(ERR_CODE), .HAS_DATA,
        .EXT_REQUEST, .CHAN_ACTIVE, .GROUP_BYTE, .DETAIL_BYTE, .RESULT,
        .ERROR_REC, .DATA_FOLLOWS, .REPORT_VALID);
    // ====================
    // tasks
    initial forever #12.5 CLK = ~CLK;
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ctl is ext, active, data, param, comm, more; load left high
    task automatic rep(input logic [3:0] c, input logic [7:0] val,
            input logic [5:0] ctl, input logic [3:0] ecl,
            input logic [7:0] edet);
        logic [2:0] eres;
        ERR_CLASS = c;
        ERR_CODE = val;
        {EXT_REQUEST, CHAN_ACTIVE, HAS_DATA, PARAM_CHANGED, cond} = ctl;
        LOAD = 1;
        eres = (ctl[5] && !ctl[4]) || !ctl[3] ? RES_ERR_NODATA : RES_ERR_DATA;
        @(posedge CLK);
        #1;
        `CHK("group", {ecl, 1'b0, ctl[2:0]}, GROUP_BYTE);
        `CHK("detail", edet, DETAIL_BYTE);
        `CHK("result", eres, RESULT);
        `CHK("follows", eres == RES_ERR_DATA, DATA_FOLLOWS);
        `CHK("valid", 1'b1, REPORT_VALID);
        `CHK("errrec", 1'b1, ERROR_REC);
    endtask
    // ====================
    // tests
    initial begin
        repeat (20) @(posedge CLK);
        #1;
        SYS_RST = 0;
        `CHK("rst group", 8'h00, GROUP_BYTE);
        `CHK("rst errrec", 1'b0, ERROR_REC);
        rep(4'h0, 8'h33, 6'h19, 4'h0, 8'h00);
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 10; i++) begin
                v = vals[i];
                rep(cls[k], v, 6'h1A, cls[k], (v <= 8'h05 ||
                    v >= VENDOR_CODE_MIN) ? v : 8'h00);
            end
        end
        rep(4'h3, 8'hFF, 6'h1C, 4'h3, 8'h7F);
        rep(4'h4, 8'hFF, 6'h1B, 4'h4, 8'h7A);
        rep(4'h5, 8'hFF, 6'h1F, 4'h5, 8'h7F);
        rep(4'h5, 8'h81, 6'h10, 4'h5, 8'h01);
        rep(4'h7, 8'hFF, 6'h18, 4'h7, 8'h00);
        rep(4'h8, 8'h55, 6'h18, 4'h8, 8'h00);
        rep(4'h9, 8'h01, 6'h18, 4'h0, 8'h00);
        rep(4'hF, 8'h01, 6'h18, 4'h0, 8'h00);
        rep(4'h2, 8'h03, 6'h2F, 4'h6, QRJ_STANDBY);
        rep(4'h2, 8'h03, 6'h3F, 4'h2, 8'h03);
        rep(4'h1, 8'h02, 6'h04, 4'h1, 8'h02);
        LOAD = 0;
        @(posedge CLK);
        #1;
        `CHK("valid off", 1'b0, REPORT_VALID);
        `CHK("hold", 8'h02, DETAIL_BYTE);
        SYS_RST = 1;
        @(posedge CLK);
        #1;
        SYS_RST = 0;
        `CHK("rst detail", 8'h00, DETAIL_BYTE);
        end_of_test;
    end
    initial begin
        #(25 * 500);
        fails++;
        end_of_test;
    end
endmodule
